// ### bench/dbgctl_core_model.sv
`timescale 1ns/1ns
module dbgctl_core_model
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // fetch control and decode
    input  wire logic       fetchHalt,
    input  wire logic [7:0] nextOpcode,
    output logic            decodeValid,
    output logic [7:0]      decodeOpcode
);
    // a halted core decodes nothing, and its stale opcode keeps moving
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            decodeValid <= 1'b0;
        else
            decodeValid <= !fetchHalt;
    end

    always_ff @(posedge clk_sys)
    begin
        decodeOpcode <= fetchHalt ? ~decodeOpcode : nextOpcode;
    end
endmodule

// ### bench/dbgctl_debug_mode_control_test.sv
`timescale 1ns/1ns
module dbgctl_debug_mode_control_test;
    import dbgctl_pkg::*;
    logic clk_sys, rst_n, readProtectOption, decodeValid, fetchHalt, breakpointNop, ackEn;
    logic systemResetReq, irq, clkEn;
    logic [7:0] regRdata, decodeOpcode, nextOpcode, lastExec;
    logic [2:0] opcodeCount;
    dbgctl_bus_s regBus;
    dbgctl_byte_s hostByte, execOpcode;
    int bad_count, compares, execCnt, nopCnt, rstCnt;

    dbgctl_debug_mode_control uut (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn),
        .regBus(regBus), .regRdata(regRdata), .readProtectOption(readProtectOption),
        .decodeValid(decodeValid), .decodeOpcode(decodeOpcode), .hostByte(hostByte),
        .opcodeCount(opcodeCount), .fetchHalt(fetchHalt), .breakpointNop(breakpointNop),
        .debugAcknowledgeEnable(ackEn), .systemResetReq(systemResetReq),
        .execOpcode(execOpcode), .irq(irq));
    dbgctl_core_model core (.clk_sys(clk_sys), .rst_n(rst_n), .fetchHalt(fetchHalt),
        .nextOpcode(nextOpcode), .decodeValid(decodeValid), .decodeOpcode(decodeOpcode));

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        if (execOpcode.valid === 1'b1)
        begin
            execCnt++;
            lastExec = execOpcode.data;
        end
        nopCnt += (breakpointNop === 1'b1);
        rstCnt += (systemResetReq === 1'b1);
    end

    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys) regBus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys) regBus.wr <= 1'b0;
    endtask

    task rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk_sys) regBus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys) regBus.rd <= 1'b0;
        @(negedge clk_sys) chk("regRdata", exp, regRdata);
    endtask

    task hb(input logic [7:0] d);
        @(posedge clk_sys) hostByte <= '{valid: 1'b1, data: d};
        @(posedge clk_sys) hostByte.valid <= 1'b0;
    endtask

    task summarize;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        #2000000;
        bad_count++;
        summarize;
    end

    initial
    begin
        rst_n = 1'b0;
        clkEn = 1'b1;
        regBus = '0;
        hostByte = '0;
        readProtectOption = 1'b0;
        nextOpcode = 8'hAA;
        opcodeCount = 3'h2;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(DBGCTL_ADDR_CTL, DBGCTL_RESET);
        wr(DBGCTL_ADDR_CTL, 8'h5E);
        rd(DBGCTL_ADDR_CTL, 8'h40);
        wr(DBGCTL_ADDR_CTL, 8'h20);
        rd(DBGCTL_ADDR_CTL, 8'h20);
        chk("ackEn", 1, ackEn);
        wr(DBGCTL_ADDR_CTL, 8'h81);
        rd(DBGCTL_ADDR_CTL, 8'h80);
        chk("fetchHalt", 1, fetchHalt);
        chk("resetPulses", 1, rstCnt[7:0]);
        chk("ackEn", 0, ackEn);
        wr(DBGCTL_ADDR_CTL, 8'h00);
        @(negedge clk_sys) chk("fetchHalt", 0, fetchHalt);
        @(posedge clk_sys) clkEn <= 1'b0;
        wr(DBGCTL_ADDR_CTL, 8'h80);
        clkEn <= 1'b1;
        rd(DBGCTL_ADDR_CTL, 8'h00);
        rd(2'h3, 8'h00);
        $display("test control done");
        wr(DBGCTL_ADDR_MASK, 8'h01);
        rd(DBGCTL_ADDR_MASK, 8'h01);
        wr(DBGCTL_ADDR_CTL, 8'h40);
        nextOpcode <= DBGCTL_BRK_OPC;
        repeat (5) @(posedge clk_sys);
        chk("fetchHalt", 1, fetchHalt);
        chk("irq", 1, irq);
        rd(DBGCTL_ADDR_STAT, 8'h01);
        wr(DBGCTL_ADDR_STAT, 8'h01);
        @(negedge clk_sys) chk("irq", 0, irq);
        wr(DBGCTL_ADDR_CTL, 8'h00);
        repeat (6) @(posedge clk_sys);
        chk("fetchHalt", 0, fetchHalt);
        chk("nopSeen", 1, 8'(nopCnt > 0));
        nextOpcode <= 8'hAA;
        $display("test breakpoint done");
        wr(DBGCTL_ADDR_CTL, 8'h80);
        hb(DBGCTL_CMD_EXEC);
        hb(8'hAB);
        hb(8'hCD);
        repeat (2) @(negedge clk_sys);
        chk("execCount", 2, execCnt[7:0]);
        chk("execData", 8'hCD, lastExec);
        @(posedge clk_sys) opcodeCount <= 3'h0;
        hb(DBGCTL_CMD_EXEC);
        hb(8'h3C);
        hb(8'h3C);
        repeat (2) @(negedge clk_sys);
        chk("execCount", 3, execCnt[7:0]);
        chk("execData", 8'h3C, lastExec);
        wr(DBGCTL_ADDR_CTL, 8'h00);
        hb(DBGCTL_CMD_EXEC);
        hb(8'h55);
        repeat (2) @(negedge clk_sys);
        chk("execCount", 3, execCnt[7:0]);
        rd(DBGCTL_ADDR_STAT, 8'h02);
        wr(DBGCTL_ADDR_STAT, 8'h02);
        $display("test execute done");
        @(posedge clk_sys) readProtectOption <= 1'b1;
        wr(DBGCTL_ADDR_CTL, 8'h80);
        wr(DBGCTL_ADDR_CTL, 8'h00);
        rd(DBGCTL_ADDR_CTL, 8'h80);
        hb(DBGCTL_CMD_EXEC);
        hb(8'h77);
        repeat (2) @(negedge clk_sys);
        chk("execCount", 3, execCnt[7:0]);
        rd(DBGCTL_ADDR_STAT, 8'h02);
        @(posedge clk_sys) rst_n <= 1'b0;
        @(posedge clk_sys) rst_n <= 1'b1;
        rd(DBGCTL_ADDR_CTL, 8'h00);
        $display("test protect done");
        summarize;
    end
endmodule

// ### design/dbgctl_debug_mode_control.sv
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
module dbgctl_debug_mode_control
    import dbgctl_pkg::*;
(
    // clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    input  wire logic                     clkEn,
    // register port
    input  wire dbgctl_pkg::dbgctl_bus_s  regBus,
    output logic [7:0]                    regRdata,
    // option straps and core decode
    input  wire logic                     readProtectOption,
    input  wire logic                     decodeValid,
    input  wire logic [7:0]               decodeOpcode,
    // host command byte stream from the serial pin receiver
    input  wire dbgctl_pkg::dbgctl_byte_s hostByte,
    input  wire logic [2:0]               opcodeCount,
    // core side
    output logic                          fetchHalt,
    output logic                          breakpointNop,
    output logic                          debugAcknowledgeEnable,
    output logic                          systemResetReq,
    output dbgctl_pkg::dbgctl_byte_s      execOpcode,
    // interrupt
    output logic                          irq
);
    import dbgctl_pkg::*;

    logic              debugHaltFlag;
    logic              breakpointAllow;
    logic              ackEnable;
    logic              resetBit;
    logic [DBGCTL_EV_W-1:0] evStatus;
    logic [DBGCTL_EV_W-1:0] evMask;
    dbgctl_cmd_e       cmdState;
    logic [2:0]        opcLeft;

    // one index decode serves the write strobes and the read checks
    function automatic logic regHit(input dbgctl_bus_s bus, input logic [1:0] regIndex);
        regHit = bus.addr == regIndex;
    endfunction

    wire ctlWr  = regBus.wr && regHit(regBus, DBGCTL_ADDR_CTL);
    wire statWr = regBus.wr && regHit(regBus, DBGCTL_ADDR_STAT);
    wire maskWr = regBus.wr && regHit(regBus, DBGCTL_ADDR_MASK);
    wire wHalt  = regBus.wdata[DBGCTL_HALT_BIT];

    // breakpoint hit only when armed; otherwise it is passed on as a no-op
    wire brkSeen = decodeValid && decodeOpcode == DBGCTL_BRK_OPC;
    wire brkHit  = brkSeen && breakpointAllow;
    // a zero in the halt bit is dropped while read protect holds the core stopped; the other fields are still written
    wire haltClearOk = !readProtectOption;
    wire next_debugHaltFlag = brkHit ? 1'b1
                            : ctlWr  ? (wHalt | (debugHaltFlag & !haltClearOk))
                            : debugHaltFlag;

    // a command is only recognised from idle, so an opcode byte is never taken as one
    wire       cmdStart  = hostByte.valid && cmdState == CMD_IDLE
                           && hostByte.data == DBGCTL_CMD_EXEC;
    wire       execAllow = debugHaltFlag && !readProtectOption;
    // out-of-range counts are clamped, not refused, so the sequencer cannot wedge
    wire [2:0] reqCount  = (opcodeCount == 3'h0) ? 3'h1
                         : (opcodeCount > DBGCTL_MAX_OPC) ? DBGCTL_MAX_OPC
                         : opcodeCount;
    wire       dropDone  = hostByte.valid && cmdState == CMD_DROP;

    wire [DBGCTL_EV_W-1:0] evSet;
    assign evSet[DBGCTL_EV_BRK]  = brkHit;
    assign evSet[DBGCTL_EV_DROP] = dropDone;

    // bits four down to one hold no storage, so they can only read zero
    wire [7:0] ctlView = {debugHaltFlag, breakpointAllow, ackEnable, 4'h0, resetBit};

    assign fetchHalt              = debugHaltFlag;
    assign breakpointNop          = brkSeen && !breakpointAllow;
    assign debugAcknowledgeEnable = ackEnable;
    assign systemResetReq         = resetBit;
    assign irq                    = |(evStatus & evMask);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            debugHaltFlag   <= DBGCTL_RESET[DBGCTL_HALT_BIT];
            breakpointAllow <= DBGCTL_RESET[DBGCTL_BRK_BIT];
            ackEnable       <= DBGCTL_RESET[DBGCTL_ACK_BIT];
            resetBit        <= DBGCTL_RESET[DBGCTL_RST_BIT];
        end
        else if (clkEn)
        begin
            debugHaltFlag <= next_debugHaltFlag;
            // reset request lasts one clkEn-enabled cycle and holds while clkEn is low; nothing here clears the other control bits in response to it
            resetBit      <= ctlWr && regBus.wdata[DBGCTL_RST_BIT];
            if (ctlWr)
            begin
                breakpointAllow <= regBus.wdata[DBGCTL_BRK_BIT];
                ackEnable       <= regBus.wdata[DBGCTL_ACK_BIT];
            end
        end
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            evStatus <= '0;
            evMask   <= '0;
        end
        else if (clkEn)
        begin
            evStatus <= (evStatus & ~(statWr ? regBus.wdata[DBGCTL_EV_W-1:0] : '0)) | evSet;
            if (maskWr)
                evMask <= regBus.wdata[DBGCTL_EV_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            regRdata <= 8'h00;
        else if (clkEn)
        begin
            case (regBus.addr)
                DBGCTL_ADDR_CTL:  regRdata <= regBus.rd ? ctlView : 8'h00;
                DBGCTL_ADDR_STAT: regRdata <= regBus.rd ? {6'h00, evStatus} : 8'h00;
                DBGCTL_ADDR_MASK: regRdata <= regBus.rd ? {6'h00, evMask} : 8'h00;
                default:          regRdata <= 8'h00;
            endcase
        end
    end

    // execute-command sequencer over the host byte stream
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmdState   <= CMD_IDLE;
            opcLeft    <= 3'h0;
            execOpcode <= '0;
        end
        else if (clkEn)
        begin
            execOpcode.valid <= 1'b0;
            case (cmdState)
                CMD_IDLE:
                begin
                    if (cmdStart)
                    begin
                        cmdState <= execAllow ? CMD_OPC : CMD_DROP;
                        opcLeft  <= reqCount;
                    end
                end
                CMD_OPC:
                begin
                    if (hostByte.valid)
                    begin
                        execOpcode.valid <= 1'b1;
                        execOpcode.data  <= hostByte.data;
                        opcLeft          <= opcLeft - 3'h1;
                        if (opcLeft == 3'h1)
                            cmdState <= CMD_IDLE;
                    end
                end
                CMD_DROP:
                begin
                    if (hostByte.valid)
                        cmdState <= CMD_IDLE;
                end
                default: cmdState <= CMD_IDLE;
            endcase
        end
    end

    // halt flag and fetch control
    haltOnBreak_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && brkHit |=> debugHaltFlag)
        else $error("breakpoint did not halt");

    nopBreak_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && brkSeen && !breakpointAllow && !ctlWr && !debugHaltFlag |=> !debugHaltFlag)
        else $error("disarmed breakpoint halted");

    protectLock_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        readProtectOption && debugHaltFlag && clkEn |=> debugHaltFlag)
        else $error("protected halt cleared");

    runWrite_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && ctlWr && !wHalt && !readProtectOption && !brkHit |=> !fetchHalt)
        else $error("run write ignored");

    haltFetch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && ctlWr && wHalt
        |=> fetchHalt)
        else $error("halt write did not stop fetch");

    haltHold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && debugHaltFlag && !ctlWr
        |=> debugHaltFlag)
        else $error("halt dropped without a write");

    runStays_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && !debugHaltFlag && !brkHit && !(ctlWr && wHalt)
        |=> !debugHaltFlag)
        else $error("halt set without a cause");

    // control register fields
    armWrite_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && ctlWr && regBus.wdata[DBGCTL_BRK_BIT]
        |=> breakpointAllow)
        else $error("breakpoint arm write lost");

    disarmWrite_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && ctlWr && !regBus.wdata[DBGCTL_BRK_BIT]
        |=> !breakpointAllow)
        else $error("breakpoint disarm write lost");

    ackWrite_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && ctlWr && regBus.wdata[DBGCTL_ACK_BIT]
        |=> debugAcknowledgeEnable)
        else $error("acknowledge enable write lost");

    resetStart_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && ctlWr && regBus.wdata[DBGCTL_RST_BIT]
        |=> systemResetReq)
        else $error("reset request not raised");

    resetPulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && !(ctlWr && regBus.wdata[DBGCTL_RST_BIT])
        |=> !systemResetReq)
        else $error("reset bit not self clearing");

    readZero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        regBus.rd && regHit(regBus, DBGCTL_ADDR_CTL) && clkEn |=> regRdata[4:1] == 4'h0)
        else $error("reserved bits not zero");

    readIdle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && !regBus.rd
        |=> regRdata == 8'h00)
        else $error("read data outside a read");

    freezeHold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !clkEn
        |=> $stable(debugHaltFlag) && $stable(evStatus) && $stable(cmdState))
        else $error("state moved while clock enable low");

    // execute-command sequencer
    dropOne_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && cmdStart && !execAllow |=> cmdState == CMD_DROP)
        else $error("execute not dropped");

    dropIdle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && dropDone
        |=> cmdState == CMD_IDLE)
        else $error("dropped byte not discarded");

    execForward_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && cmdState == CMD_OPC && hostByte.valid
        |=> execOpcode.valid)
        else $error("opcode byte not forwarded");

    execIdle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && cmdState != CMD_OPC
        |=> !execOpcode.valid)
        else $error("opcode forwarded outside a command");

    execEnd_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && cmdState == CMD_OPC && hostByte.valid && opcLeft == 3'h1
        |=> cmdState == CMD_IDLE)
        else $error("command did not end after its last byte");

    opcBound_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmdState == CMD_OPC
        |-> opcLeft != 3'h0 && opcLeft <= DBGCTL_MAX_OPC)
        else $error("opcode count out of range");

    // event status and interrupt
    dropFlag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && dropDone
        |=> evStatus[DBGCTL_EV_DROP])
        else $error("drop event not recorded");

    statusSticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && evStatus[DBGCTL_EV_BRK] && !statWr
        |=> evStatus[DBGCTL_EV_BRK])
        else $error("breakpoint status lost");

    irqRaise_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkEn && brkHit && evMask[DBGCTL_EV_BRK] && !maskWr
        |=> irq)
        else $error("unmasked event raised no interrupt");
endmodule

// ### design/dbgctl_pkg.sv
package dbgctl_pkg;
    // control register layout
    localparam logic [7:0] DBGCTL_RESET     = 8'h00;
    localparam int         DBGCTL_HALT_BIT  = 7;
    localparam int         DBGCTL_BRK_BIT   = 6;
    localparam int         DBGCTL_ACK_BIT   = 5;
    localparam int         DBGCTL_RST_BIT   = 0;
    localparam logic [7:0] DBGCTL_WMASK     = 8'hE1;

    // register offsets, one per byte index
    localparam logic [1:0] DBGCTL_ADDR_CTL  = 2'h0;
    localparam logic [1:0] DBGCTL_ADDR_STAT = 2'h1;
    localparam logic [1:0] DBGCTL_ADDR_MASK = 2'h2;

    // interrupt status bits
    localparam int         DBGCTL_EV_BRK    = 0;
    localparam int         DBGCTL_EV_DROP   = 1;
    localparam int         DBGCTL_EV_W      = 2;

    // core-side opcodes and command
    localparam logic [7:0] DBGCTL_BRK_OPC   = 8'h00;
    localparam logic [7:0] DBGCTL_CMD_EXEC  = 8'h12;
    localparam logic [2:0] DBGCTL_MAX_OPC   = 3'h5;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } dbgctl_bus_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } dbgctl_byte_s;

    typedef enum logic [1:0] {
        CMD_IDLE,
        CMD_OPC,
        CMD_DROP
    } dbgctl_cmd_e;
endpackage
